/* src/ceba_device.sv */
// Converter end: enable control, fault latch, strap address and bus target.
//
// The address-and-strobe port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`include "ceba_consts.svh"
module ceba_device import ceba_pkg::*; (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // Link
  ceba_link_if.dev        link,
  // Converter side
  input  wire logic [9:0] strap_mv,
  input  wire logic       fault_stop,
  output logic            convert_on,
  output logic            fault_latched,
  output logic            phase_shed_on,
  output logic            continuous_conduction,
  output logic [6:0]      target_addr,
  output logic            addr_ready
);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic scl_s1_q, scl_s2_q, scl_s3_q, sda_s1_q, sda_s2_q, sda_s3_q, en_s1_q, en_s2_q;
  logic [9:0] strap_s1_q, strap_s2_q;

  // Three flops on the scl and sda pins give two for safety and one for edge finding;
  // at 40 MHz this keeps the 1 MHz class within margin.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      scl_s1_q <= 1'b1; scl_s2_q <= 1'b1; scl_s3_q <= 1'b1;
      sda_s1_q <= 1'b1; sda_s2_q <= 1'b1; sda_s3_q <= 1'b1;
      en_s1_q <= 1'b0; en_s2_q <= 1'b0;
      strap_s1_q <= 10'h000; strap_s2_q <= 10'h000;
    end else begin
      scl_s1_q <= link.scl; scl_s2_q <= scl_s1_q; scl_s3_q <= scl_s2_q;
      sda_s1_q <= link.sda; sda_s2_q <= sda_s1_q; sda_s3_q <= sda_s2_q;
      en_s1_q <= link.en; en_s2_q <= en_s1_q;
      strap_s1_q <= strap_mv; strap_s2_q <= strap_s1_q;
    end
  end

  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise  = scl_s2_q && !scl_s3_q;
  assign scl_fall  = !scl_s2_q && scl_s3_q;
  assign bus_start = scl_s2_q && scl_s3_q && sda_s3_q && !sda_s2_q;
  assign bus_stop  = scl_s2_q && scl_s3_q && !sda_s3_q && sda_s2_q;

  // ----------------------------------------
  // Address strap
  // ----------------------------------------
  logic [1:0]  settle_q, settle_d;
  logic [6:0]  addr_q, addr_d;
  logic        addr_rdy_q, addr_rdy_d;
  logic [10:0] strap_idx;

  always_comb begin
    // Windows are 49 mV apart; the bias puts each edge between two centres.
    strap_idx = (11'(strap_s2_q) + `CEBA_STRAP_BIAS_MV) / `CEBA_STRAP_STEP_MV;
    if (strap_idx > `CEBA_ADDR_STEPS) begin
      strap_idx = `CEBA_ADDR_STEPS;
    end
    settle_d   = settle_q;
    addr_d     = addr_q;
    addr_rdy_d = addr_rdy_q;
    if (!addr_rdy_q) begin
      settle_d = settle_q + 2'h1;
      if (settle_q == `CEBA_STRAP_SETTLE) begin
        addr_d     = `CEBA_ADDR_BASE + strap_idx[6:0];
        addr_rdy_d = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      settle_q <= 2'h0; addr_q <= `CEBA_ADDR_BASE; addr_rdy_q <= 1'b0;
    end else begin
      settle_q <= settle_d; addr_q <= addr_d; addr_rdy_q <= addr_rdy_d;
    end
  end

  // ----------------------------------------
  // Bus target
  // ----------------------------------------
  ceba_tgt_st_t st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d, cmd_q, cmd_d, op_q, op_d, onoff_q, onoff_d, rd_byte;
  logic       rw_q, rw_d, idx_q, idx_d, oe_n_q, oe_n_d, shed_q, shed_d;

  always_comb begin
    st_d = st_q; cnt_d = cnt_q; sh_d = sh_q; cmd_d = cmd_q; op_d = op_q;
    onoff_d = onoff_q; rw_d = rw_q; idx_d = idx_q; oe_n_d = oe_n_q; shed_d = shed_q;
    case (cmd_q)
      `CEBA_CMD_OPERATION: rd_byte = op_q;
      `CEBA_CMD_ON_OFF:    rd_byte = onoff_q;
      `CEBA_CMD_SHED:      rd_byte = {7'h00, shed_q};
      default:             rd_byte = 8'h00;
    endcase
    if (bus_start) begin
      st_d = CEBA_T_ADDR; cnt_d = 4'h0; idx_d = 1'b0; oe_n_d = 1'b1;
    end else if (bus_stop) begin
      st_d = CEBA_T_IDLE; oe_n_d = 1'b1;
    end else begin
      case (st_q)
        CEBA_T_IDLE: oe_n_d = 1'b1;
        CEBA_T_ADDR, CEBA_T_RX: begin
          if (scl_rise && cnt_q < `CEBA_BYTE_BITS) begin
            sh_d  = {sh_q[6:0], sda_s2_q};
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == `CEBA_BYTE_BITS) begin
            if (st_q == CEBA_T_RX) begin
              if (!idx_q) begin
                cmd_d = sh_q;
              end else if (cmd_q == `CEBA_CMD_OPERATION) begin
                op_d = sh_q;
              end else if (cmd_q == `CEBA_CMD_ON_OFF) begin
                onoff_d = sh_q;
              end else if (cmd_q == `CEBA_CMD_SHED) begin
                shed_d = sh_q[0];
              end
              idx_d  = 1'b1;
              oe_n_d = 1'b0;
              st_d   = CEBA_T_ACK;
            end else if (addr_rdy_q && sh_q[7:1] == addr_q) begin
              rw_d   = sh_q[0];
              oe_n_d = 1'b0;
              st_d   = CEBA_T_ACK;
            end else begin
              st_d = CEBA_T_IDLE;
            end
          end
        end
        CEBA_T_ACK: begin
          if (scl_fall) begin
            cnt_d = 4'h0;
            if (rw_q) begin
              sh_d   = rd_byte;
              oe_n_d = rd_byte[7];
              st_d   = CEBA_T_TX;
            end else begin
              oe_n_d = 1'b1;
              st_d   = CEBA_T_RX;
            end
          end
        end
        CEBA_T_TX: begin
          if (scl_fall) begin
            if (cnt_q == `CEBA_BYTE_BITS - 4'h1) begin
              oe_n_d = 1'b1;
              st_d   = CEBA_T_MACK;
            end else begin
              sh_d   = {sh_q[6:0], 1'b0};
              oe_n_d = sh_q[6];
              cnt_d  = cnt_q + 4'h1;
            end
          end
        end
        CEBA_T_MACK: begin
          if (scl_rise) begin
            st_d = sda_s2_q ? CEBA_T_IDLE : CEBA_T_ACK;
          end
        end
        default: begin
          st_d = CEBA_T_IDLE; oe_n_d = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_q <= CEBA_T_IDLE; cnt_q <= 4'h0; sh_q <= 8'h00; cmd_q <= 8'h00;
      op_q <= `CEBA_OP_RST; onoff_q <= `CEBA_ONOFF_RST;
      rw_q <= 1'b0; idx_q <= 1'b0; oe_n_q <= 1'b1;
      shed_q <= 1'b0;
    end else begin
      st_q <= st_d; cnt_q <= cnt_d; sh_q <= sh_d; cmd_q <= cmd_d;
      op_q <= op_d; onoff_q <= onoff_d;
      rw_q <= rw_d; idx_q <= idx_d; oe_n_q <= oe_n_d;
      shed_q <= shed_d;
    end
  end

  // ----------------------------------------
  // Conversion control
  // ----------------------------------------
  logic pin_sel, cmd_sel, ctrl_on;
  logic run_q, run_d, fault_q, fault_d, conduct_q;

  always_comb begin
    // With neither source selected the pin keeps control rather than locking off.
    cmd_sel = onoff_q[`CEBA_ONOFF_CMD_BIT];
    pin_sel = onoff_q[`CEBA_ONOFF_PIN_BIT] || !cmd_sel;
    ctrl_on = (!pin_sel || en_s2_q) && (!cmd_sel || op_q[`CEBA_OP_ON_BIT]);
    // A new fault wins over the clear that a low enable would give.
    fault_d = fault_stop || (fault_q && ctrl_on);
    run_d   = ctrl_on && !fault_q && !fault_stop;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      run_q <= 1'b0; fault_q <= 1'b0; conduct_q <= 1'b0;
    end else begin
      run_q <= run_d; fault_q <= fault_d;
      conduct_q <= 1'b1;
    end
  end

  assign link.sda_dev_o    = 1'b0;
  assign link.sda_dev_oe_n = oe_n_q;
  assign convert_on            = run_q;
  assign fault_latched         = fault_q;
  assign phase_shed_on         = shed_q;
  assign continuous_conduction = conduct_q;
  assign target_addr           = addr_q;
  assign addr_ready            = addr_rdy_q;

endmodule

/* src/ceba_consts.svh */
// Constants shared by both ends of the converter enable and bus address link.
// Function
// - Phase shedding off at reset; bus command enables.
// - Conversion starts only when selected sources high.
// - After fault, stay off until enable low-high.
// - Pin-only mode follows pin, ignores command.
// - Reset configuration selects pin-only control.
// - Pin low stops conversion at once.
// - Command-only mode follows command, ignores pin.
// - Combined mode needs pin and command both.
// - Target works at 100k, 400k, 1M classes.
// - Target address comes from strap voltage.
// - Seven-bit address above direction bit, 1=read.
// - Strap windows step address from 1011000b to 1100100b.
// - Converter runs continuous conduction, fixed frequency.
`ifndef CEBA_CONSTS_SVH
`define CEBA_CONSTS_SVH

// ----------------------------------------
// Command codes and fields
// ----------------------------------------
`define CEBA_CMD_OPERATION 8'h01
`define CEBA_CMD_ON_OFF    8'h02
`define CEBA_CMD_SHED      8'hd0
`define CEBA_OP_ON_BIT     7
`define CEBA_ONOFF_CMD_BIT 3
`define CEBA_ONOFF_PIN_BIT 2
`define CEBA_ONOFF_RST     8'h14
`define CEBA_OP_RST        8'h00
`define CEBA_BYTE_BITS     4'h8

// ----------------------------------------
// Address strap decode
// ----------------------------------------
`define CEBA_ADDR_BASE     7'h58
`define CEBA_ADDR_STEPS    11'h00c
`define CEBA_STRAP_BIAS_MV 11'h009
`define CEBA_STRAP_STEP_MV 11'h031
`define CEBA_STRAP_SETTLE  2'h3

// ----------------------------------------
// Timing
// ----------------------------------------
`define CEBA_CLK_PERIOD_NS 25
`define CEBA_SCL_PERIOD_NS 10000
`define CEBA_QTR_CYC       (`CEBA_SCL_PERIOD_NS / (4 * `CEBA_CLK_PERIOD_NS))

`endif

/* src/ceba_pkg.sv */
// Types shared by both ends of the converter enable and bus address link.
package ceba_pkg;

  // ----------------------------------------
  // Device target states
  // ----------------------------------------
  typedef enum logic [5:0] {
    CEBA_T_IDLE = 6'h01,
    CEBA_T_ADDR = 6'h02,
    CEBA_T_ACK  = 6'h04,
    CEBA_T_RX   = 6'h08,
    CEBA_T_TX   = 6'h10,
    CEBA_T_MACK = 6'h20
  } ceba_tgt_st_t;

  // ----------------------------------------
  // Host controller states
  // ----------------------------------------
  typedef enum logic [3:0] {
    CEBA_H_IDLE  = 4'h1,
    CEBA_H_START = 4'h2,
    CEBA_H_BIT   = 4'h4,
    CEBA_H_STOP  = 4'h8
  } ceba_host_st_t;

endpackage

/* src/ceba_link_if.sv */
// Link between the host controller and the converter: clock, data and enable pins.
`timescale 1ns/10ps
interface ceba_link_if;
  logic scl;
  logic en;
  logic sda_host_o;
  logic sda_host_oe_n;
  logic sda_dev_o;
  logic sda_dev_oe_n;
  logic sda;

  // Open-drain wire: any end that drives low wins, otherwise pulled high.
  assign sda = !((!sda_host_oe_n && !sda_host_o) || (!sda_dev_oe_n && !sda_dev_o));

  modport host (output scl, output en, output sda_host_o, output sda_host_oe_n, input sda);
  modport dev  (input scl, input en, output sda_dev_o, output sda_dev_oe_n, input sda);
endinterface

/* src/ceba_host.sv */
// Host controller end: drives enable and issues byte writes and reads on the link.
`timescale 1ns/10ps
`include "ceba_consts.svh"
module ceba_host import ceba_pkg::*; #(
  parameter int QTR_CYC = `CEBA_QTR_CYC
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // Link
  ceba_link_if.host       link,
  // User requests
  input  wire logic       en_req,
  input  wire logic       req,
  input  wire logic       req_rd,
  input  wire logic [6:0] req_addr,
  input  wire logic [7:0] req_cmd,
  input  wire logic [7:0] req_data,
  // User status
  output logic            busy,
  output logic            done,
  output logic            nack,
  output logic [7:0]      rdata
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  ceba_host_st_t st_q, st_d;
  logic [15:0]   div_q, div_d;
  logic [1:0]    ph_q, ph_d, byte_q, byte_d;
  logic [3:0]    bit_q, bit_d;
  logic [8:0]    tx_q, tx_d;
  logic [7:0]    rx_q, rx_d, cmd_q, cmd_d, data_q, data_d, rdata_q, rdata_d;
  logic [6:0]    addr_q, addr_d;
  logic          rd_q, rd_d, scl_q, scl_d, oe_n_q, oe_n_d, en_q, en_d;
  logic          busy_q, busy_d, done_q, done_d, nack_q, nack_d;
  logic          sda_s1_q, sda_s2_q, tick;
  logic [7:0]    nxt_byte;

  assign link.scl           = scl_q;
  assign link.en            = en_q;
  assign link.sda_host_o    = 1'b0;
  assign link.sda_host_oe_n = oe_n_q;
  assign busy               = busy_q;
  assign done               = done_q;
  assign nack               = nack_q;
  assign rdata              = rdata_q;

  // ----------------------------------------
  // Next values
  // ----------------------------------------
  always_comb begin
    st_d = st_q; div_d = div_q; ph_d = ph_q; byte_d = byte_q; bit_d = bit_q;
    tx_d = tx_q; rx_d = rx_q; cmd_d = cmd_q; data_d = data_q; rdata_d = rdata_q;
    addr_d = addr_q; rd_d = rd_q; scl_d = scl_q; oe_n_d = oe_n_q;
    busy_d = busy_q; nack_d = nack_q;
    done_d = 1'b0;
    en_d   = en_req;
    tick   = (st_q != CEBA_H_IDLE) && (div_q == 16'h0000);
    // The address byte goes out first, direction in bit 0.
    case (byte_q + 2'h1)
      2'h1:    nxt_byte = cmd_q;
      2'h2:    nxt_byte = rd_q ? {addr_q, 1'b1} : data_q;
      default: nxt_byte = 8'hff;
    endcase
    if (st_q != CEBA_H_IDLE) begin
      div_d = tick ? 16'(QTR_CYC - 1) : div_q - 16'h0001;
    end
    if (tick) begin
      ph_d = ph_q + 2'h1;
    end
    case (st_q)
      CEBA_H_IDLE: begin
        if (req) begin
          addr_d = req_addr; cmd_d = req_cmd; data_d = req_data; rd_d = req_rd;
          byte_d = 2'h0; busy_d = 1'b1; nack_d = 1'b0; ph_d = 2'h0;
          div_d  = 16'(QTR_CYC - 1);
          tx_d   = {req_addr, 1'b0, 1'b1};
          st_d   = CEBA_H_START;
        end
      end
      CEBA_H_START: begin
        if (tick) begin
          case (ph_q)
            2'h0:    oe_n_d = 1'b1;
            2'h1:    scl_d = 1'b1;
            2'h2:    oe_n_d = 1'b0;
            default: begin
              scl_d = 1'b0; bit_d = 4'h0; st_d = CEBA_H_BIT;
            end
          endcase
        end
      end
      CEBA_H_BIT: begin
        if (tick) begin
          case (ph_q)
            2'h0:    oe_n_d = tx_q[8];
            2'h1:    scl_d = 1'b1;
            2'h2:    if (bit_q < `CEBA_BYTE_BITS) rx_d = {rx_q[6:0], sda_s2_q};
            default: begin
              scl_d = 1'b0;
              tx_d  = {tx_q[7:0], 1'b0};
              bit_d = bit_q + 4'h1;
              if (bit_q == `CEBA_BYTE_BITS) begin
                bit_d = 4'h0;
                if (sda_s2_q && byte_q != 2'h3) begin
                  nack_d = 1'b1; st_d = CEBA_H_STOP;
                end else if (byte_q == 2'h3 || (!rd_q && byte_q == 2'h2)) begin
                  rdata_d = rx_q; st_d = CEBA_H_STOP;
                end else begin
                  byte_d = byte_q + 2'h1;
                  tx_d   = {nxt_byte, 1'b1};
                  if (rd_q && byte_q == 2'h1) st_d = CEBA_H_START;
                end
              end
            end
          endcase
        end
      end
      CEBA_H_STOP: begin
        if (tick) begin
          case (ph_q)
            2'h0:    oe_n_d = 1'b0;
            2'h1:    scl_d = 1'b1;
            2'h2:    oe_n_d = 1'b1;
            default: begin
              busy_d = 1'b0; done_d = 1'b1; st_d = CEBA_H_IDLE;
            end
          endcase
        end
      end
      default: st_d = CEBA_H_IDLE;
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_q <= CEBA_H_IDLE; div_q <= 16'h0000; ph_q <= 2'h0; byte_q <= 2'h0;
      bit_q <= 4'h0; tx_q <= 9'h1ff; rx_q <= 8'h00; cmd_q <= 8'h00; data_q <= 8'h00;
      rdata_q <= 8'h00; addr_q <= 7'h00; rd_q <= 1'b0; scl_q <= 1'b1; oe_n_q <= 1'b1;
      en_q <= 1'b0; busy_q <= 1'b0; done_q <= 1'b0; nack_q <= 1'b0;
      sda_s1_q <= 1'b1; sda_s2_q <= 1'b1;
    end else begin
      st_q <= st_d; div_q <= div_d; ph_q <= ph_d; byte_q <= byte_d;
      bit_q <= bit_d; tx_q <= tx_d; rx_q <= rx_d; cmd_q <= cmd_d; data_q <= data_d;
      rdata_q <= rdata_d; addr_q <= addr_d; rd_q <= rd_d; scl_q <= scl_d; oe_n_q <= oe_n_d;
      en_q <= en_d; busy_q <= busy_d; done_q <= done_d; nack_q <= nack_d;
      sda_s1_q <= link.sda; sda_s2_q <= sda_s1_q;
    end
  end

endmodule

/* verification/ceba_checker.sv */
// Checker for the link and the enable and fault behaviour of both ends.
`timescale 1ns/10ps
module ceba_checker (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       rst_n,
  // Link
  input wire logic       scl,
  input wire logic       sda,
  input wire logic       sda_dev_oe_n,
  // End status
  input wire logic       busy,
  input wire logic       done,
  input wire logic       fault_stop,
  input wire logic       fault_latched,
  input wire logic       convert_on,
  input wire logic       addr_ready,
  input wire logic [6:0] target_addr
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_scl_idle_high: assert property (!busy |-> scl)
    else $error("scl low while host idle");
  a_stop_framing: assert property (done |-> scl && sda)
    else $error("link not released at end of transfer");
  a_busy_after_done: assert property (done |-> !busy)
    else $error("host still busy after done");
  a_dev_bit_stable: assert property ($changed(sda_dev_oe_n) |-> !scl)
    else $error("device changed sda while scl high");
  a_quiet_unready: assert property (!addr_ready |-> sda_dev_oe_n)
    else $error("device drove sda before address ready");
  a_addr_range: assert property (addr_ready |-> target_addr inside {[7'h58:7'h64]})
    else $error("target address outside strap range");
  a_addr_held: assert property ($past(addr_ready) |-> $stable(target_addr))
    else $error("target address changed after decode");
  a_fault_stops: assert property (fault_stop |=> !convert_on && fault_latched)
    else $error("fault did not stop conversion");
  a_fault_holds: assert property (fault_latched |-> !convert_on)
    else $error("conversion on while fault latched");
  a_start_clean: assert property ($rose(convert_on) |-> !$past(fault_latched))
    else $error("conversion started from latched fault");

  c_fault: cover property (fault_stop ##1 fault_latched);
  c_start: cover property ($rose(convert_on));
  c_ack: cover property ($fell(sda_dev_oe_n));
  c_done: cover property (done);
endmodule

/* verification/converter_enable_and_bus_address_tb.sv */
// Testbench: host and converter ends joined over the link, checked end to end.
`timescale 1ns/10ps
`include "ceba_consts.svh"
module converter_enable_and_bus_address_tb;
  logic       core_clk, rst_n, en_req, req, req_rd, fault_stop;
  logic [6:0] req_addr, target_addr;
  logic [7:0] req_cmd, req_data, rdata;
  logic [9:0] strap_mv;
  logic       busy, done, nack, convert_on, fault_latched, phase_shed_on, cont_cond, addr_ready;
  int         n_fail, checks_done;

  ceba_link_if link ();
  // A 1 MHz class host keeps the run short.
  ceba_host #(.QTR_CYC(10)) ceba_host_i (
    .core_clk(core_clk), .rst_n(rst_n), .link(link), .en_req(en_req), .req(req),
    .req_rd(req_rd), .req_addr(req_addr), .req_cmd(req_cmd), .req_data(req_data),
    .busy(busy), .done(done), .nack(nack), .rdata(rdata));
  ceba_device ceba_device_i (
    .core_clk(core_clk), .rst_n(rst_n), .link(link), .strap_mv(strap_mv),
    .fault_stop(fault_stop), .convert_on(convert_on), .fault_latched(fault_latched),
    .phase_shed_on(phase_shed_on), .continuous_conduction(cont_cond),
    .target_addr(target_addr), .addr_ready(addr_ready));
  ceba_checker ceba_checker_i (
    .core_clk(core_clk), .rst_n(rst_n), .scl(link.scl), .sda(link.sda),
    .sda_dev_oe_n(link.sda_dev_oe_n), .busy(busy), .done(done), .fault_stop(fault_stop),
    .fault_latched(fault_latched), .convert_on(convert_on), .addr_ready(addr_ready),
    .target_addr(target_addr));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic final_report();
    if (n_fail == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
  endtask

  task automatic do_reset(input logic [9:0] mv);
    rst_n <= 1'b0;
    strap_mv <= mv;
    cyc(20);
    rst_n <= 1'b1;
    cyc(8);
  endtask

  task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] c,
                      input logic [7:0] d);
    int k;
    k = 0;
    @(posedge core_clk);
    req <= 1'b1;
    req_rd <= rd;
    req_addr <= a;
    req_cmd <= c;
    req_data <= d;
    @(posedge core_clk);
    req <= 1'b0;
    while (done !== 1'b1 && k < 4000) begin
      @(posedge core_clk);
      k++;
    end
    chk("done", 8'(done), 8'h01);
    cyc(4);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_strap();
    logic [9:0] mv [5] = '{10'h000, 10'h027, 10'h049, 10'h13d, 10'h262};
    logic [6:0] ad [5] = '{7'h58, 7'h58, 7'h59, 7'h5e, 7'h64};
    for (int i = 0; i < 5; i++) begin
      do_reset(mv[i]);
      chk("target_addr", 8'(target_addr), 8'(ad[i]));
      strap_mv <= 10'h000;
      cyc(8);
      chk("addr_held", 8'(target_addr), 8'(ad[i]));
    end
    xfer(1'b0, 7'h58, `CEBA_CMD_OPERATION, 8'h80);
    chk("nack_other", 8'(nack), 8'h01);
    xfer(1'b1, 7'h64, `CEBA_CMD_ON_OFF, 8'h00);
    chk("nack_own", 8'(nack), 8'h00);
    chk("rd_onoff", rdata, `CEBA_ONOFF_RST);
  endtask

  task automatic t_defaults();
    do_reset(10'h000);
    chk("cont_cond", 8'(cont_cond), 8'h01);
    chk("shed_rst", 8'(phase_shed_on), 8'h00);
    xfer(1'b1, 7'h58, `CEBA_CMD_SHED, 8'h00);
    chk("rd_shed", rdata, 8'h00);
    xfer(1'b0, 7'h58, `CEBA_CMD_SHED, 8'h01);
    chk("shed_on", 8'(phase_shed_on), 8'h01);
  endtask

  task automatic t_modes();
    en_req <= 1'b1;
    cyc(6);
    chk("pin_on", 8'(convert_on), 8'h01);
    xfer(1'b0, 7'h58, `CEBA_CMD_OPERATION, 8'h00);
    chk("pin_ignores_op", 8'(convert_on), 8'h01);
    en_req <= 1'b0;
    cyc(5);
    chk("pin_off_fast", 8'(convert_on), 8'h00);
    xfer(1'b0, 7'h58, `CEBA_CMD_ON_OFF, 8'h08);
    xfer(1'b0, 7'h58, `CEBA_CMD_OPERATION, 8'h80);
    chk("cmd_on", 8'(convert_on), 8'h01);
    en_req <= 1'b1;
    cyc(5);
    en_req <= 1'b0;
    cyc(5);
    chk("cmd_ignores_pin", 8'(convert_on), 8'h01);
    xfer(1'b0, 7'h58, `CEBA_CMD_OPERATION, 8'h00);
    chk("cmd_off", 8'(convert_on), 8'h00);
    xfer(1'b0, 7'h58, `CEBA_CMD_ON_OFF, 8'h0c);
    xfer(1'b0, 7'h58, `CEBA_CMD_OPERATION, 8'h80);
    chk("both_pin_low", 8'(convert_on), 8'h00);
    en_req <= 1'b1;
    cyc(6);
    chk("both_on", 8'(convert_on), 8'h01);
    xfer(1'b0, 7'h58, `CEBA_CMD_OPERATION, 8'h00);
    chk("both_op_low", 8'(convert_on), 8'h00);
  endtask

  task automatic t_fault();
    xfer(1'b0, 7'h58, `CEBA_CMD_ON_OFF, `CEBA_ONOFF_RST);
    chk("pin_restart", 8'(convert_on), 8'h01);
    fault_stop <= 1'b1;
    cyc(1);
    fault_stop <= 1'b0;
    cyc(1);
    chk("fault_off", 8'(convert_on), 8'h00);
    chk("fault_set", 8'(fault_latched), 8'h01);
    cyc(20);
    chk("fault_stays", 8'(convert_on), 8'h00);
    en_req <= 1'b0;
    cyc(8);
    chk("fault_clear", 8'(fault_latched), 8'h00);
    en_req <= 1'b1;
    cyc(8);
    chk("fault_resume", 8'(convert_on), 8'h01);
  endtask

  // ----------------------------------------
  // Clock, sequence and watchdog
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  initial begin
    rst_n = 1'b0;
    en_req = 1'b0;
    req = 1'b0;
    req_rd = 1'b0;
    req_addr = 7'h00;
    req_cmd = 8'h00;
    req_data = 8'h00;
    fault_stop = 1'b0;
    strap_mv = 10'h000;
    n_fail = 0;
    checks_done = 0;
    t_strap();
    t_defaults();
    t_modes();
    t_fault();
    final_report();
  end

  // Roughly four times the expected run; a hung handshake ends here.
  initial begin
    repeat (60000) @(posedge core_clk);
    n_fail++;
    final_report();
  end
endmodule
